// ===== src/dpw_pkg.sv
// Package: timing constants and carriers for the dual-port RAM write-port controller
package dpw_pkg;
  localparam int CLK_NS = 25;
  // Device figures in ns, fastest grade
  localparam int WP_NS = 15;
  localparam int WZ_NS = 10;
  localparam int DATA_SETUP_TO_END_NS = 10;
  localparam int FLAG_ASSERT_FROM_ADDR_NS = 20;
  localparam int POST_FLAG_WRITE_HOLD_NS = 12;
  localparam int SLAVE_FLAG_LEAD_NS = 0;
  localparam int WR_NS = 0;
  localparam int WDD_NS = 50;
  localparam int DATA_TO_CROSSREAD_DELAY_NS = 35;
  // Least times round up, never below one cycle
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int SETUP_CYC = min_cyc(FLAG_ASSERT_FROM_ADDR_NS);
  localparam int WP_OE_LO_NS = (WP_NS > WZ_NS + DATA_SETUP_TO_END_NS) ? WP_NS : WZ_NS + DATA_SETUP_TO_END_NS;
  localparam int PULSE_CYC_OE_LO = min_cyc(WP_OE_LO_NS);
  localparam int PULSE_CYC_OE_HI = min_cyc(WP_NS);
  localparam int FLOAT_CYC = min_cyc(WZ_NS);
  localparam int HOLD_CYC = min_cyc(POST_FLAG_WRITE_HOLD_NS);
  localparam int REC_CYC = min_cyc(WR_NS);
  localparam int XREAD_CYC = min_cyc(WDD_NS);
  localparam logic [3:0] CNT_W1 = 4'h1;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
  } dpw_req_s;

  typedef struct packed {
    logic ce_n;
    logic rw_n;
    logic oe_n;
    logic [10:0] addr;
  } dpw_pins_s;
endpackage

// ===== src/dpw_cnt.sv
// Down counter used to time the phases of a write
`timescale 1ns/1ps
`default_nettype none
module dpw_cnt
  import dpw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [3:0] load_val,
  output logic done
);
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;

  // Count down to zero; a load restarts the phase
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (load)
      nxt_cnt = load_val;
    else if (cnt_ff != 4'h0)
      nxt_cnt = cnt_ff - CNT_W1;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;
  end

  // Done reads the count alone, since the sequencer's load depends on it and gating would close a loop
  assign done = (cnt_ff == 4'h0);
endmodule
`default_nettype wire

// ===== src/dpw_host.sv
// Host-side write controller for one port of a dual-port static RAM
`timescale 1ns/1ps
`default_nettype none
module dpw_host
  import dpw_pkg::*;
#(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire dpw_req_s req,
  input wire logic oe_low_mode,
  output logic req_ready,
  output logic done_pulse,
  output logic busy_seen,
  output var dpw_pins_s pins,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic flag_n
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_FLOAT = 6'b000100,
    ST_PULSE = 6'b001000,
    ST_HOLD  = 6'b010000,
    ST_REC   = 6'b100000
  } dpw_state_e;

  dpw_state_e st_ff, nxt_st;
  dpw_pins_s pins_ff, nxt_pins;
  logic [DATA_W-1:0] dq_ff, nxt_dq;
  logic dq_oe_ff, nxt_dq_oe;
  logic ready_ff, nxt_ready;
  logic done_ff, nxt_done;
  logic busy_ff, nxt_busy;
  logic oe_lo_ff, nxt_oe_lo;
  logic ld;
  logic [3:0] ld_val;
  logic t_done;
  logic unused_dq;

  assign unused_dq = ^dq_in;

  dpw_cnt u_cnt (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(ld),
    .load_val(ld_val),
    .done(t_done)
  );

  // Sequencer: address, float wait, strobe pulse, flag hold, recovery
  always_comb
  begin
    nxt_st = st_ff;
    nxt_pins = pins_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_ready = 1'b0;
    nxt_done = 1'b0;
    nxt_busy = busy_ff;
    nxt_oe_lo = oe_lo_ff;
    ld = 1'b0;
    ld_val = 4'h0;
    case (st_ff)
      ST_IDLE:
      begin
        nxt_ready = 1'b1;
        if (req_valid && ready_ff)
        begin
          nxt_ready = 1'b0;
          nxt_pins.addr = req.addr[ADDR_W-1:0];
          nxt_pins.oe_n = !oe_low_mode;
          nxt_oe_lo = oe_low_mode;
          nxt_dq = req.data;
          nxt_busy = 1'b0;
          ld = 1'b1;
          ld_val = 4'(SETUP_CYC);
          nxt_st = ST_ADDR;
        end
      end
      ST_ADDR:
        if (t_done)
        begin
          nxt_pins.rw_n = 1'b0;
          ld = 1'b1;
          ld_val = 4'(FLOAT_CYC);
          nxt_st = ST_FLOAT;
        end
      ST_FLOAT:
        if (t_done)
        begin
          nxt_pins.ce_n = 1'b0;
          nxt_dq_oe = 1'b1;
          ld = 1'b1;
          ld_val = oe_lo_ff ? 4'(PULSE_CYC_OE_LO) : 4'(PULSE_CYC_OE_HI);
          nxt_st = ST_PULSE;
        end
      ST_PULSE:
      begin
        if (!flag_n)
          nxt_busy = 1'b1;
        if (t_done && flag_n)
        begin
          if (busy_ff)
          begin
            ld = 1'b1;
            ld_val = 4'(HOLD_CYC);
            nxt_st = ST_HOLD;
          end
          else
          begin
            nxt_pins.rw_n = 1'b1;
            nxt_pins.ce_n = 1'b1;
            ld = 1'b1;
            ld_val = 4'(REC_CYC);
            nxt_st = ST_REC;
          end
        end
      end
      ST_HOLD:
        if (!flag_n)
        begin
          ld = 1'b1;
          ld_val = 4'(HOLD_CYC);
        end
        else if (t_done)
        begin
          nxt_pins.rw_n = 1'b1;
          nxt_pins.ce_n = 1'b1;
          ld = 1'b1;
          ld_val = 4'(REC_CYC);
          nxt_st = ST_REC;
        end
      ST_REC:
        if (t_done)
        begin
          nxt_dq_oe = 1'b0;
          nxt_pins.oe_n = 1'b1;
          nxt_done = 1'b1;
          nxt_ready = 1'b1;
          nxt_st = ST_IDLE;
        end
      default:
      begin
        nxt_st = ST_IDLE;
        nxt_pins.ce_n = 1'b1;
        nxt_pins.rw_n = 1'b1;
        nxt_dq_oe = 1'b0;
      end
    endcase
  end

  // Registers only; every output leaves from here
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= ST_IDLE;
      pins_ff <= '{ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, addr: 11'h000};
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
      oe_lo_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      pins_ff <= nxt_pins;
      dq_ff <= nxt_dq;
      dq_oe_ff <= nxt_dq_oe;
      ready_ff <= nxt_ready;
      done_ff <= nxt_done;
      busy_ff <= nxt_busy;
      oe_lo_ff <= nxt_oe_lo;
    end
  end

  assign pins = pins_ff;
  assign dq_out = dq_ff;
  assign dq_oe = dq_oe_ff;
  assign req_ready = ready_ff;
  assign done_pulse = done_ff;
  assign busy_seen = busy_ff;

  // Checks on the pin sequence
  sequence strobe_fall_s;
    $fell(pins_ff.rw_n);
  endsequence

  sequence select_fall_s;
    $fell(pins_ff.ce_n);
  endsequence

  addr_stable_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(pins_ff.addr) |-> $past(pins_ff.rw_n) && pins_ff.rw_n)
    else $error("address moved with strobe low");
  strobe_first_a: assert property (@(posedge mclk) disable iff (!rst_n)
    select_fall_s |-> !$past(pins_ff.rw_n))
    else $error("select fell before strobe");
  setup_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strobe_fall_s |-> $past(st_ff) == ST_ADDR && $past(pins_ff.rw_n, 2))
    else $error("strobe fell without address wait");
  data_hidden_a: assert property (@(posedge mclk) disable iff (!rst_n)
    strobe_fall_s |-> !dq_oe_ff ##1 !dq_oe_ff)
    else $error("data driven before float time");
  pulse_width_a: assert property (@(posedge mclk) disable iff (!rst_n)
    select_fall_s |-> !pins_ff.ce_n [*1] ##1 !pins_ff.ce_n)
    else $error("write window too short");
  data_valid_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!pins_ff.ce_n && !pins_ff.rw_n) |-> dq_oe_ff && $stable(dq_ff))
    else $error("data not stable in write window");
  flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (busy_ff && !pins_ff.ce_n && $rose(flag_n)) |-> !pins_ff.rw_n ##1 !pins_ff.rw_n)
    else $error("strobe released too soon after flag");
  write_ends_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff == ST_PULSE && flag_n && t_done && !busy_ff) |=> pins_ff.rw_n && pins_ff.ce_n ##[1:2] done_ff)
    else $error("write did not finish");
  busy_mark_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_ff == ST_PULSE && !flag_n) |=> busy_ff)
    else $error("flag not recorded");
endmodule
`default_nettype wire

// ===== sim/dpw_ram.sv
// Behavioural model of one RAM port with a commanded contention flag
`timescale 1ns/1ps
`default_nettype none
module dpw_ram
  import dpw_pkg::*;
(
  input wire logic mclk,
  input wire dpw_pins_s pins,
  input wire logic [7:0] dq_host,
  input wire logic dq_host_oe,
  input wire logic flag_cmd,
  output logic [7:0] dq_bus,
  output logic dq_ram_oe,
  output logic flag_n
);
  logic [7:0] mem [0:2047];
  logic [7:0] last_ff;
  // Flag only while selected; the bench picks which port loses
  assign flag_n = ~(flag_cmd & ~pins.ce_n);
  // Drive only in a read state, so a strobe falling first keeps it floating
  assign dq_ram_oe = ~pins.ce_n & pins.rw_n & ~pins.oe_n;
  // A read shows the cell at once, inside the cross-port bounds; an undriven bus toggles
  assign dq_bus = dq_ram_oe ? mem[pins.addr] : (dq_host_oe ? dq_host : ~last_ff);
  // Store during the overlap only, and never while flagged
  always @(posedge mclk)
  begin
    last_ff <= dq_bus;
    if (!pins.ce_n && !pins.rw_n && flag_n)
      mem[pins.addr] <= dq_bus;
  end
endmodule
`default_nettype wire

// ===== sim/test_dual_port_write_busy_timing.sv
// Self-checking bench for the dual-port RAM write controller
`timescale 1ns/1ps
`default_nettype none
module test_dual_port_write_busy_timing;
  import dpw_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  dpw_req_s req = '0;
  logic oe_low_mode = 1'b0;
  logic flag_cmd = 1'b0;
  logic req_ready, done_pulse, busy_seen, dq_oe, dq_ram_oe, flag_n;
  dpw_pins_s pins;
  logic [7:0] dq_bus, dq_out;
  dpw_pins_s prev_ff;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int ovl = 0;
  // Each phase spans its count plus one edge; one more edge takes the request, and the negedge after done's edge sees it
  localparam int WR_LAT = SETUP_CYC + FLOAT_CYC + PULSE_CYC_OE_LO + REC_CYC + 5;
  localparam int WR_LAT_HI = SETUP_CYC + FLOAT_CYC + PULSE_CYC_OE_HI + REC_CYC + 5;
  always #12.5 mclk = ~mclk;
  dpw_host dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .oe_low_mode(oe_low_mode),
    .req_ready(req_ready), .done_pulse(done_pulse), .busy_seen(busy_seen), .pins(pins), .dq_in(dq_bus),
    .dq_out(dq_out), .dq_oe(dq_oe), .flag_n(flag_n));
  dpw_ram u_ram (.mclk(mclk), .pins(pins), .dq_host(dq_out), .dq_host_oe(dq_oe), .flag_cmd(flag_cmd),
    .dq_bus(dq_bus), .dq_ram_oe(dq_ram_oe), .flag_n(flag_n));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Pin monitor and cycle ceiling
  always @(negedge mclk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      error_cnt++;
      print_verdict();
    end
    if (rst_n)
    begin
      if (pins.addr !== prev_ff.addr)
        check("addr_in_window", prev_ff.ce_n | prev_ff.rw_n, 1'b1);
      if (prev_ff.ce_n && !pins.ce_n)
        check("strobe_first", pins.rw_n, 1'b0);
      check("bus_clash", dq_oe & dq_ram_oe, 1'b0);
      if (!pins.ce_n && !pins.rw_n)
      begin
        ovl++;
        check("gate_level", pins.oe_n, !oe_low_mode);
      end
      else if (ovl > 0)
      begin
        check("pulse_len", ovl >= (pins.oe_n ? PULSE_CYC_OE_HI : PULSE_CYC_OE_LO), 1'b1);
        ovl = 0;
      end
    end
    prev_ff = pins;
  end
  // One write; returns cycles from take to done
  task automatic do_write(input logic [10:0] a, input logic [7:0] d, input logic oe, output int n);
    logic r;
    r = 1'b0;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{addr: a, data: d};
    oe_low_mode <= oe;
    while (!r)
    begin
      @(negedge mclk);
      r = (req_ready === 1'b1);
      @(posedge mclk);
    end
    req_valid <= 1'b0;
    while (n < 100 && done_pulse !== 1'b1)
    begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic t_basic();
    int n;
    do_write(11'h000, 8'hA5, 1'b0, n);
    check("latency", n, WR_LAT);
    check("stored", u_ram.mem[11'h000], 8'hA5);
    check("no_busy", busy_seen, 1'b0);
  endtask
  task automatic t_back_to_back();
    int n;
    do_write(11'h7FF, 8'h5A, 1'b1, n);
    check("latency_hi", n, WR_LAT_HI);
    do_write(11'h7FE, 8'hC3, 1'b1, n);
    check("stored_hi", u_ram.mem[11'h7FF], 8'h5A);
    check("stored_next", u_ram.mem[11'h7FE], 8'hC3);
  endtask
  task automatic t_busy();
    int n;
    do_write(11'h123, 8'h00, 1'b0, n);
    @(posedge mclk);
    flag_cmd <= 1'b1;
    fork
      do_write(11'h123, 8'h3C, 1'b0, n);
      begin
        repeat (8) @(negedge mclk);
        check("busy_flag", busy_seen, 1'b1);
        check("inhibited", u_ram.mem[11'h123], 8'h00);
        check("strobe_held", pins.rw_n, 1'b0);
        @(posedge mclk);
        flag_cmd <= 1'b0;
        @(negedge mclk);
        check("hold_after", pins.rw_n, 1'b0);
        // First edge that sees the flag high must still leave the strobe low
        @(negedge mclk);
        check("hold_after_edge", pins.rw_n, 1'b0);
      end
    join
    check("retried", u_ram.mem[11'h123], 8'h3C);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_basic();
    t_back_to_back();
    t_busy();
    print_verdict();
  end
endmodule
`default_nettype wire
